/* File: bench/sre_return_exec_assertions.sv */
// Purpose: timing checks for the return unit
// Assumes: one clock, synchronous reset
// Notes: cycle 0 is the taking edge
`timescale 1ns/1ns
`include "sre_regs.vh"
module sre_return_exec_assertions (
    input wire clk_sys,
    input wire rst_n,
    input wire op_valid,
    input wire [13:0] op_word,
    input wire [12:0] stack_head_entry,
    input wire stack_pop,
    input wire pc_load,
    input wire [12:0] pc_value,
    input wire [7:0] acc_value,
    input wire acc_load,
    input wire busy,
    input wire second_cycle
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire take = op_valid && !busy;
    wire lit = take && op_word[13:10] == 4'hd;
    wire ret = take && op_word == `SRE_RETURN_OP;
    AST_LIT: assert property (lit |->
        ##3 (acc_load && acc_value == $past(op_word[7:0], 3)))
        else $error("literal not written");
    AST_PC: assert property ((lit || ret) |->
        ##3 (pc_load && pc_value == $past(stack_head_entry)))
        else $error("return address not loaded");
    AST_RET: assert property (ret |=> !stack_pop[*2] ##1 (stack_pop && !acc_load))
        else $error("pop not in last phase");
    AST_SECOND: assert property ((lit || ret) |->
        ##4 second_cycle[*4] ##1 !second_cycle)
        else $error("second cycle not four phases");
    AST_BUSY: assert property (lit || ret |=> busy[*7] ##1 !busy)
        else $error("not two cycles");
    AST_IDLE: assert property (second_cycle |-> !stack_pop && !acc_load && !pc_load)
        else $error("second cycle not idle");
endmodule // sre_return_exec_assertions
bind sre_return_exec sre_return_exec_assertions chk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .op_valid(op_valid),
    .op_word(op_word),
    .stack_head_entry(stack_head_entry),
    .stack_pop(stack_pop),
    .pc_load(pc_load),
    .pc_value(pc_value),
    .acc_value(acc_value),
    .acc_load(acc_load),
    .busy(busy),
    .second_cycle(second_cycle)
);

/* File: bench/sre_return_exec_test.sv */
// Purpose: table bench for the return unit
// Assumes: inputs change on falling edges
// Notes: a return is offered while busy and must be ignored
`timescale 1ns/1ns
module sre_return_exec_test;
    logic clk_sys = 0, rst_n = 0, op_valid = 0, p, a;
    logic [13:0] op_word = 14'h0000;
    logic [12:0] stack_head_entry = 13'h0000;
    logic [7:0] lit, acc_value;
    logic [12:0] pc_value;
    logic [3:0] phase;
    logic stack_pop, pc_load, acc_load, busy, second_cycle;
    int n_fail = 0, compares = 0, k;
    logic [35:0] rows [7] = '{{14'h3455, 13'h0123, 1'b1, 8'h55},
        {14'h3700, 13'h1fff, 1'b1, 8'h00}, {14'h0008, 13'h0abc, 1'b1, 8'h00},
        {14'h0009, 13'h0000, 1'b0, 8'h00}, {14'h3c55, 13'h0000, 1'b0, 8'h00},
        {14'h35a5, 13'h1555, 1'b1, 8'ha5}, {14'h0008, 13'h0aaa, 1'b1, 8'ha5}};
    sre_return_exec dut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .op_valid(op_valid),
        .op_word(op_word),
        .stack_head_entry(stack_head_entry),
        .stack_pop(stack_pop),
        .pc_value(pc_value),
        .pc_load(pc_load),
        .acc_value(acc_value),
        .acc_load(acc_load),
        .busy(busy),
        .phase(phase),
        .second_cycle(second_cycle)
    );
    initial forever #4 clk_sys = ~clk_sys;
    task chk(input logic c);
        compares++;
        if (c !== 1'b1) begin
            n_fail++;
            $display("mismatch %0t wrong output", $time);
        end
    endtask
    task test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_sys);
        chk(pc_value === 13'h0000 && acc_value === 8'h00 && phase === 4'h1 && busy === 1'b0);
        rst_n = 1;
        foreach (rows[i]) begin
            {op_word, stack_head_entry, p, lit} = rows[i];
            a = p & op_word[13];
            op_valid = 1;
            @(negedge clk_sys);
            op_valid = p;
            op_word = 14'h0008;
            repeat (2) @(negedge clk_sys) op_valid = 0;
            chk(stack_pop === p && pc_load === p && acc_load === a);
            chk(acc_value === lit);
            if (p) chk(pc_value === stack_head_entry);
            chk(phase === (p ? 4'h8 : 4'h1) && second_cycle === 1'b0);
            @(negedge clk_sys);
            chk(second_cycle === p && stack_pop === 1'b0 && acc_load === 1'b0);
            for (k = 0; k < 9 && busy !== 1'b0; k++) @(negedge clk_sys);
            if (busy !== 1'b0) begin
                n_fail++;
                test_done;
            end
            chk(stack_pop === 1'b0 && second_cycle === 1'b0);
        end
        {op_valid, op_word} = {1'b1, 14'h34ff};
        repeat (2) @(negedge clk_sys) op_valid = 0;
        rst_n = 0;
        @(negedge clk_sys);
        chk(busy === 1'b0 && phase === 4'h1 && acc_value === 8'h00 && pc_value === 13'h0000);
        rst_n = 1;
        {op_valid, op_word} = {1'b1, 14'h3412};
        @(negedge clk_sys);
        op_valid = 0;
        repeat (2) @(negedge clk_sys);
        chk(acc_load === 1'b1 && acc_value === 8'h12 && pc_value === stack_head_entry);
        test_done;
    end
endmodule // sre_return_exec_test

/* File: core/sre_regs.vh */
// Purpose: constants for the subroutine-return execution unit
// Assumes: 14-bit instruction words, 8-bit accumulator, 13-bit program counter
// Notes: phase codes are one-hot, one bit per core clock of an instruction cycle
`ifndef SRE_REGS_VH
`define SRE_REGS_VH
`define SRE_OP_W 14
`define SRE_DATA_W 8
`define SRE_PC_W 13
`define SRE_TOP_HI 13
`define SRE_TOP_LO 12
`define SRE_TOP_RET 2'h3
`define SRE_MID_HI 11
`define SRE_MID_LO 10
`define SRE_MID_LIT 2'h1
`define SRE_LIT_HI 7
`define SRE_LIT_LO 0
`define SRE_RETURN_OP 14'h0008
`define SRE_PH_Q1 4'h1
`define SRE_PH_Q2 4'h2
`define SRE_PH_Q3 4'h4
`define SRE_PH_Q4 4'h8
`define SRE_ACC_RST 8'h00
`define SRE_PC_RST 13'h0000
`endif

/* File: core/sre_return_exec.v */
// Purpose: execute the plain return and the literal return of an 8-bit core,
//     both of which pop the return stack into the program counter
// Assumes: op_valid is offered in phase Q1 of an instruction cycle; all inputs synchronous;
//     stack_head_entry shows the current top of the stack and is read at the Q3 edge
// Notes: each instruction cycle is four clocks; the second cycle of a return is idle;
//     a word offered while busy is dropped without notice, so the decoder must wait;
//     stack depth and overflow belong to the stack itself
// Overview of operation
// - Literal-return opcode 11 01xx kkkkkkkk writes the literal byte into the accumulator.
// - Literal return loads the stack head entry into the program counter.
// - Plain return opcode 0x0008 pops the stack into the program counter, no flags.
// - Plain return takes two cycles: pop in Q4 of first, second cycle idle.
`timescale 1ns/1ns
`include "sre_regs.vh"
module sre_return_exec (
    input wire clk_sys,
    input wire rst_n,
    input wire op_valid,
    input wire [`SRE_OP_W-1:0] op_word,
    input wire [`SRE_PC_W-1:0] stack_head_entry,
    output reg stack_pop,
    output reg [`SRE_PC_W-1:0] pc_value,
    output reg pc_load,
    output reg [`SRE_DATA_W-1:0] acc_value,
    output reg acc_load,
    output wire busy,
    output reg [3:0] phase,
    output reg second_cycle
);
    // One-hot states; IDLE waits for a decode, FIRST and SECOND are the two instruction cycles
    localparam ST_IDLE = 3'b001;
    localparam ST_FIRST = 3'b010;
    localparam ST_SECOND = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [3:0] next_phase;
    reg is_literal;
    reg [`SRE_DATA_W-1:0] lit_hold;
    reg [`SRE_DATA_W-1:0] lit_latch;
    wire [3:0] phase_turned;
    wire dec_literal;
    wire dec_return;
    wire start;
    wire in_idle;
    wire in_first;
    wire in_second;
    wire at_q2;
    wire at_q3;
    wire at_q4;
    wire act_point;

    // Bits 9:8 of the literal-return word are don't-care and are not decoded
    assign dec_literal = (op_word[`SRE_TOP_HI:`SRE_TOP_LO] == `SRE_TOP_RET) &&
        (op_word[`SRE_MID_HI:`SRE_MID_LO] == `SRE_MID_LIT);
    assign dec_return = (op_word == `SRE_RETURN_OP);
    // Any other word is left to the rest of the core and ignored here
    assign start = in_idle && op_valid && (dec_literal || dec_return);

    assign in_idle = (state == ST_IDLE);
    assign in_first = (state == ST_FIRST);
    assign in_second = (state == ST_SECOND);
    assign at_q2 = (phase == `SRE_PH_Q2);
    assign at_q3 = (phase == `SRE_PH_Q3);
    assign at_q4 = (phase == `SRE_PH_Q4);

    // Busy stays high over both instruction cycles so the decoder holds off
    assign busy = !in_idle;

    // One-hot phase ring: each bit takes its lower neighbour, Q1 takes Q4
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ring
            assign phase_turned[g] = phase[(g + 3) % 4];
        end
    endgenerate

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_FIRST;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_FIRST: begin
                if (at_q4) begin
                    next_state = ST_SECOND;
                end else begin
                    next_state = ST_FIRST;
                end
            end
            ST_SECOND: begin
                if (at_q4) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_SECOND;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @* begin
        next_phase = phase;
        if (start) begin
            next_phase = `SRE_PH_Q2;
        end else if (!in_idle) begin
            // Phase ring only turns while an instruction is in flight
            next_phase = phase_turned;
        end else begin
            next_phase = `SRE_PH_Q1;
        end
    end

    // Reset returns the ring to Q1 so the first decode after it lands in Q1
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            phase <= `SRE_PH_Q1;
        end else begin
            phase <= next_phase;
        end
    end

    // Marks the idle second cycle for the decoder and for debug
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            second_cycle <= 1'b0;
        end else if (in_idle) begin
            second_cycle <= 1'b0;
        end else if (at_q4) begin
            second_cycle <= in_first;
        end
    end

    // Kind of return is remembered for the whole instruction
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            is_literal <= 1'b0;
        end else if (start) begin
            is_literal <= dec_literal;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            lit_hold <= `SRE_ACC_RST;
        end else if (start) begin
            // Word is captured at decode since the fetch may move on
            lit_hold <= op_word[`SRE_LIT_HI:`SRE_LIT_LO];
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            lit_latch <= `SRE_ACC_RST;
        end else if (in_first && at_q2 && is_literal) begin
            lit_latch <= lit_hold;
        end
    end

    // Timing of a return, counted in clocks from the decode edge:
    //   edge 0 decodes in Q1 and captures the word
    //   edge 1 closes Q2 and reads the literal
    //   edge 2 closes Q3 and raises the strobes with the popped address and literal
    //   edge 3 closes Q4; the stack pops, the program counter loads and, for a literal return only, the accumulator loads
    //   edges 4 to 7 are the idle second cycle; busy falls after edge 7
    // Registering at the Q3 edge keeps every strobe inside the first cycle,
    // so the second cycle stays free of any operation
    assign act_point = in_first && at_q3;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            stack_pop <= 1'b0;
        end else begin
            stack_pop <= act_point;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pc_load <= 1'b0;
        end else begin
            pc_load <= act_point;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_load <= 1'b0;
        end else begin
            acc_load <= act_point && is_literal;
        end
    end

    // Address and literal hold until the next return of their kind
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pc_value <= `SRE_PC_RST;
        end else if (act_point) begin
            pc_value <= stack_head_entry;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_value <= `SRE_ACC_RST;
        end else if (act_point && is_literal) begin
            acc_value <= lit_latch;
        end
    end
endmodule // sre_return_exec
